// ---- cspm_pkg.sv ----
// package: register map, field codes and reset values for the chip-select pin assignment block
package cspm_pkg;

  localparam int          CSPM_ADDR_W   = 8;
  localparam int          CSPM_DATA_W   = 16;
  localparam int          CSPM_NUM_PINS = 11;
  localparam int          CSPM_LOW_PINS = 6;

  // register offsets
  localparam logic [7:0]  OFF_LATCH     = 8'h40;
  localparam logic [7:0]  OFF_SEL_LOW   = 8'h44;
  localparam logic [7:0]  OFF_SEL_HIGH  = 8'h46;
  localparam logic [7:0]  OFF_BOOT_BASE = 8'h48;

  // pin function codes
  localparam logic [1:0]  FN_DISCRETE   = 2'h0;
  localparam logic [1:0]  FN_ALT        = 2'h1;
  localparam logic [1:0]  FN_CS8        = 2'h2;
  localparam logic [1:0]  FN_CS16       = 2'h3;

  // field layout
  localparam int          SEL_LOW_W     = 14;
  localparam int          SEL_HIGH_W    = 10;
  localparam int          LATCH_W       = 7;
  localparam int          FIELD_W       = 2;
  localparam int          LOW_FIRST_LSB = 2;
  localparam int          BOOT_HI_BIT   = 1;
  localparam int          BASE_ADDR_LSB = 3;
  localparam int          BASE_ADDR_W   = 13;
  localparam int          BUS_ADDR_W    = 24;
  localparam int          BUS_CMP_LSB   = 11;
  localparam int          STRAP_W       = 8;
  localparam int          STRAP_HIGH_LO = 3;
  localparam int          STRAP_LOW_HI  = 2;
  localparam int          STRAP_LOW_MID = 1;
  localparam int          DISC_FIRST    = 3;

  // reset values
  localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
  localparam logic [6:0]  LATCH_RST     = 7'h00;

  // compare masks over base address bits 23:11, indexed by block size code
  localparam logic [7:0][12:0] BLK_MASK = {
    13'h1e00, 13'h1f00, 13'h1f80, 13'h1fc0,
    13'h1fe0, 13'h1ff8, 13'h1ffc, 13'h1fff
  };

endpackage

// ---- cspm_pin_drive.sv ----
// module: output stage of one chip-select pin, steered by its function field
module cspm_pin_drive #(
  parameter bit HAS_DISCRETE = 1'b1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // function and sources
  input  wire logic [1:0] pin_fn,
  input  wire logic       discrete_val,
  input  wire logic       alt_val,
  input  wire logic       cs_req,
  // pin
  output logic            pin_out,
  output logic            pin_oe_n,
  output logic            port_16bit
);
  import cspm_pkg::*;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_out    <= 1'b1;
      pin_oe_n   <= 1'b1;
      port_16bit <= 1'b0;
    end else begin
      port_16bit <= (pin_fn == FN_CS16);
      case (pin_fn)
        FN_DISCRETE: begin
          // pins without a discrete output are left undriven
          pin_out  <= HAS_DISCRETE ? discrete_val : 1'b1;
          pin_oe_n <= !HAS_DISCRETE;
        end
        FN_ALT: begin
          pin_out  <= alt_val;
          pin_oe_n <= 1'b0;
        end
        default: begin
          // chip-selects are active low on the pin
          pin_out  <= !cs_req;
          pin_oe_n <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- cspm_top.sv ----
// module: chip-select pin assignment registers, discrete latch, boot select base and pin mux
////////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: the register addresses and strobed register access.

module cspm_top (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  // register port
  input  wire logic [cspm_pkg::CSPM_ADDR_W-1:0]  reg_addr,
  input  wire logic [cspm_pkg::CSPM_DATA_W-1:0]  reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [cspm_pkg::CSPM_DATA_W-1:0]  reg_rdata,
  // data bus pins sampled during reset
  input  wire logic [cspm_pkg::STRAP_W-1:0]      data_pin,
  // function sources
  input  wire logic [cspm_pkg::CSPM_NUM_PINS-1:0] alt_fn_in,
  input  wire logic [cspm_pkg::CSPM_NUM_PINS-1:0] cs_req_in,
  input  wire logic                              e_phase_clock,
  // bus address for the boot select
  input  wire logic [cspm_pkg::BUS_ADDR_W-1:0]   bus_addr,
  input  wire logic                              bus_addr_valid,
  // chip-select pins
  output logic      [cspm_pkg::CSPM_NUM_PINS-1:0] cs_pin_out,
  output logic      [cspm_pkg::CSPM_NUM_PINS-1:0] cs_pin_oe_n,
  output logic      [cspm_pkg::CSPM_NUM_PINS-1:0] cs_port_16bit,
  // boot select pin
  output logic                                   boot_memory_select_n,
  output logic                                   boot_port_16bit
);
  import cspm_pkg::*;

  logic [STRAP_W-1:0]      strap_m_r;
  logic [STRAP_W-1:0]      strap_s_r;
  logic [SEL_LOW_W-1:0]    sel_low_r;
  logic [SEL_HIGH_W-1:0]   sel_high_r;
  logic [LATCH_W-1:0]      latch_r;
  logic [15:0]             boot_base_r;
  logic [CSPM_DATA_W-1:0]  rdata_nxt;
  logic [SEL_LOW_W-1:0]    sel_low_rst;
  logic [SEL_HIGH_W-1:0]   sel_high_rst;
  logic [BASE_ADDR_W-1:0]  cmp_mask;
  logic                    boot_hit;
  logic                    strap_all_w;
  logic [1:0]              pin_fn [CSPM_NUM_PINS];

  ////////////////////////////////////////////////////////////////////////////////
  // data bus straps: two-stage synchroniser, sampled while reset is held

  always_ff @(posedge clk) begin
    strap_m_r <= data_pin;
    strap_s_r <= strap_m_r;
  end

  always_comb begin
    logic acc;
    acc = 1'b1;
    // low register reset image
    sel_low_rst = {strap_s_r[STRAP_LOW_HI], 1'b1, strap_s_r[STRAP_LOW_HI], 1'b1,
                   strap_s_r[STRAP_LOW_HI], 1'b1, strap_s_r[STRAP_LOW_MID], 1'b1,
                   strap_s_r[STRAP_LOW_MID], 1'b1, strap_s_r[STRAP_LOW_MID], 1'b1,
                   1'b1, strap_s_r[0]};
    // first zero from the top turns that pin and all below into address lines
    sel_high_rst = '0;
    for (int k = CSPM_NUM_PINS - CSPM_LOW_PINS - 1; k >= 0; k--) begin
      acc = acc & strap_s_r[STRAP_HIGH_LO + k];
      sel_high_rst[FIELD_W*k+1] = acc;
      sel_high_rst[FIELD_W*k]   = 1'b1;
    end
  end

  assign strap_all_w = &strap_s_r[STRAP_W-1:STRAP_HIGH_LO];

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_low_r <= sel_low_rst;
    end else if (reg_wr && reg_addr == OFF_SEL_LOW) begin
      // boot field high bit pinned so the boot pin stays a chip-select
      sel_low_r <= {reg_wdata[SEL_LOW_W-1:BOOT_HI_BIT+1], 1'b1, reg_wdata[0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_high_r <= sel_high_rst;
    end else if (reg_wr && reg_addr == OFF_SEL_HIGH) begin
      sel_high_r <= reg_wdata[SEL_HIGH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_r <= LATCH_RST;
    end else if (reg_wr && reg_addr == OFF_LATCH) begin
      latch_r <= reg_wdata[LATCH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_base_r <= BOOT_BASE_RST;
    end else if (reg_wr && reg_addr == OFF_BOOT_BASE) begin
      boot_base_r <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the strobe, zero elsewhere

  always_comb begin
    rdata_nxt = '0;
    if (reg_addr == OFF_SEL_LOW) begin
      rdata_nxt[SEL_LOW_W-1:0] = sel_low_r;
    end else if (reg_addr == OFF_SEL_HIGH) begin
      rdata_nxt[SEL_HIGH_W-1:0] = sel_high_r;
    end else if (reg_addr == OFF_LATCH) begin
      rdata_nxt[LATCH_W-1:0] = latch_r;
    end else if (reg_addr == OFF_BOOT_BASE) begin
      rdata_nxt = boot_base_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin multiplexers

  for (genvar i = 0; i < CSPM_NUM_PINS; i++) begin : g_pin
    logic disc_w;
    if (i < CSPM_LOW_PINS) begin : g_low
      assign pin_fn[i] = sel_low_r[FIELD_W*i+LOW_FIRST_LSB+1:FIELD_W*i+LOW_FIRST_LSB];
    end else begin : g_high
      assign pin_fn[i] = sel_high_r[FIELD_W*(i-CSPM_LOW_PINS)+1:FIELD_W*(i-CSPM_LOW_PINS)];
    end
    if (i == CSPM_NUM_PINS - 1) begin : g_phase
      assign disc_w = e_phase_clock;
    end else if (i >= DISC_FIRST) begin : g_latch
      assign disc_w = latch_r[i-DISC_FIRST];
    end else begin : g_none
      assign disc_w = 1'b1;
    end
    cspm_pin_drive #(
      .HAS_DISCRETE (i >= DISC_FIRST)
    ) u_drive (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .pin_fn       (pin_fn[i]),
      .discrete_val (disc_w),
      .alt_val      (alt_fn_in[i]),
      .cs_req       (cs_req_in[i]),
      .pin_out      (cs_pin_out[i]),
      .pin_oe_n     (cs_pin_oe_n[i]),
      .port_16bit   (cs_port_16bit[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // boot select: compare only the bits above the block size

  assign cmp_mask = BLK_MASK[boot_base_r[BASE_ADDR_LSB-1:0]];
  // a base not aligned to the block is masked anyway, low bits never matter
  assign boot_hit = bus_addr_valid &&
    (((bus_addr[BUS_ADDR_W-1:BUS_CMP_LSB] ^ boot_base_r[15:BASE_ADDR_LSB]) & cmp_mask)
     == '0);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      boot_memory_select_n <= 1'b1;
      boot_port_16bit      <= 1'b0;
    end else begin
      boot_memory_select_n <= !boot_hit;
      boot_port_16bit      <= sel_low_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence rd_at(logic [7:0] off);
    reg_rd && reg_addr == off;
  endsequence

  sequence fn_held(int idx, logic [1:0] code);
    pin_fn[idx] == code;
  endsequence

  sequence wr_at(logic [7:0] off);
    reg_wr && reg_addr == off;
  endsequence

  low_top_zero_a: assert property (rd_at(OFF_SEL_LOW) |=> reg_rdata[15:14] == 2'h0)
    else $error("low register top bits not zero");

  boot_bit_one_a: assert property (rd_at(OFF_SEL_LOW) |=> reg_rdata[1] == 1'b1)
    else $error("boot field upper bit not one");

  boot_kept_cs_a: assert property (
      reg_wr && reg_addr == OFF_SEL_LOW && !reg_wdata[1] |=> sel_low_r[1])
    else $error("boot field left chip-select");

  high_top_zero_a: assert property (rd_at(OFF_SEL_HIGH) |=> reg_rdata[15:10] == 6'h00)
    else $error("high register top bits not zero");

  low_strap_a: assert property ($fell(sys_rst) |->
      sel_low_r[13:12] == {$past(strap_s_r[2]), 1'b1} &&
      sel_low_r[3:2] == {$past(strap_s_r[1]), 1'b1} &&
      sel_low_r[1:0] == {1'b1, $past(strap_s_r[0])})
    else $error("low register strap load wrong");

  high_strap_a: assert property ($fell(sys_rst) |->
      sel_high_r[9:8] == {$past(strap_s_r[7]), 1'b1} &&
      sel_high_r[1:0] == {$past(strap_all_w), 1'b1})
    else $error("high register strap load wrong");

  boot_base_rst_a: assert property ($fell(sys_rst) |-> boot_base_r == BOOT_BASE_RST)
    else $error("boot base reset value wrong");

  discrete_pin_a: assert property (fn_held(3, FN_DISCRETE) |=>
      cs_pin_out[3] == $past(latch_r[0]) && !cs_pin_oe_n[3])
    else $error("discrete pin not following latch");

  no_discrete_a: assert property (fn_held(1, FN_DISCRETE) |=> cs_pin_oe_n[1])
    else $error("pin without discrete output driven");

  alt_pin_a: assert property (fn_held(7, FN_ALT) |=> cs_pin_out[7] == $past(alt_fn_in[7]))
    else $error("alternate function not routed");

  cs_pin_a: assert property (pin_fn[4][1] |=>
      cs_pin_out[4] == !$past(cs_req_in[4]) && cs_port_16bit[4] == $past(pin_fn[4][0]))
    else $error("chip-select pin wrong");

  boot_match_a: assert property (bus_addr_valid && boot_base_r[2:0] == 3'h7 &&
      bus_addr[23:20] == boot_base_r[15:12] |=> !boot_memory_select_n)
    else $error("boot select missed a 1M block hit");

  low_write_a: assert property (wr_at(OFF_SEL_LOW) |=>
      sel_low_r[13:2] == $past(reg_wdata[13:2]) && sel_low_r[0] == $past(reg_wdata[0]))
    else $error("low register write lost");

  high_write_a: assert property (wr_at(OFF_SEL_HIGH) |=>
      sel_high_r == $past(reg_wdata[9:0]))
    else $error("high register write lost");

  base_write_a: assert property (wr_at(OFF_BOOT_BASE) |=>
      boot_base_r == $past(reg_wdata))
    else $error("boot base write lost");

  latch_write_a: assert property (wr_at(OFF_LATCH) |=>
      latch_r == $past(reg_wdata[6:0]))
    else $error("discrete latch write lost");

  high_read_a: assert property (rd_at(OFF_SEL_HIGH) |=>
      reg_rdata[9:0] == $past(sel_high_r))
    else $error("high register read wrong");

  latch_read_a: assert property (rd_at(OFF_LATCH) |=>
      reg_rdata == {9'h000, $past(latch_r)})
    else $error("discrete latch read wrong");

  base_read_a: assert property (rd_at(OFF_BOOT_BASE) |=>
      reg_rdata == $past(boot_base_r))
    else $error("boot base read wrong");

  phase_pin_a: assert property (fn_held(10, FN_DISCRETE) |=>
      cs_pin_out[10] == $past(e_phase_clock) && !cs_pin_oe_n[10])
    else $error("e clock not on its pin");

  alt_low_a: assert property (fn_held(5, FN_ALT) |=>
      cs_pin_out[5] == $past(alt_fn_in[5]) && !cs_pin_oe_n[5])
    else $error("function code not routed");

  boot_idle_a: assert property (!bus_addr_valid |=> boot_memory_select_n)
    else $error("boot select without a bus cycle");

endmodule

// ---- cspm_far_model.sv ----
// far side of the chip-select pins: memories and peripherals behind a board pull-up
module cspm_far_model (
  // pins from the block
  input  wire logic [cspm_pkg::CSPM_NUM_PINS-1:0] pin_out,
  input  wire logic [cspm_pkg::CSPM_NUM_PINS-1:0] pin_oe_n,
  // levels seen on the board
  output logic      [cspm_pkg::CSPM_NUM_PINS-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import cspm_pkg::*;
  // an undriven select pin floats high, so no memory is ever selected by accident
  assign pin_level = pin_out | pin_oe_n;
endmodule

// ---- chip_select_pin_assignment_test.sv ----
// testbench for the chip-select pin assignment block
module chip_select_pin_assignment_test;
  timeunit 1ns;
  timeprecision 1ps;
  import cspm_pkg::*;
  logic clk, sys_rst, reg_wr, reg_rd, e_phase_clock, bus_addr_valid;
  logic boot_memory_select_n, boot_port_16bit;
  logic [7:0]  reg_addr, data_pin;
  logic [15:0] reg_wdata, reg_rdata;
  logic [10:0] alt_fn_in, cs_req_in, cs_pin_out, cs_pin_oe_n, cs_port_16bit, pin_level;
  logic [23:0] bus_addr;
  int          failures, n_compared;
  cspm_top u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_pin(data_pin),
    .alt_fn_in(alt_fn_in), .cs_req_in(cs_req_in), .e_phase_clock(e_phase_clock),
    .bus_addr(bus_addr), .bus_addr_valid(bus_addr_valid), .cs_pin_out(cs_pin_out),
    .cs_pin_oe_n(cs_pin_oe_n), .cs_port_16bit(cs_port_16bit),
    .boot_memory_select_n(boot_memory_select_n), .boot_port_16bit(boot_port_16bit));
  cspm_far_model u_far (.pin_out(cs_pin_out), .pin_oe_n(cs_pin_oe_n), .pin_level(pin_level));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic read_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset images come from the straps
  task automatic test_reset(input logic [7:0] strap, input logic [15:0] lo, input logic [15:0] hi);
    data_pin <= strap;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    read_chk(OFF_SEL_LOW, lo);
    read_chk(OFF_SEL_HIGH, hi);
    read_chk(OFF_BOOT_BASE, BOOT_BASE_RST);
    read_chk(OFF_LATCH, 16'h0000);
    $display("test reset straps %h done", strap);
  endtask
  // fixed and unused bits, plain read and write
  task automatic test_regs;
    write_reg(OFF_SEL_LOW, 16'hffff);
    read_chk(OFF_SEL_LOW, 16'h3fff);
    write_reg(OFF_SEL_LOW, 16'h0000);
    read_chk(OFF_SEL_LOW, 16'h0002);
    chk({15'h0000, boot_port_16bit}, 16'h0000);
    write_reg(OFF_SEL_HIGH, 16'hffff);
    read_chk(OFF_SEL_HIGH, 16'h03ff);
    write_reg(OFF_LATCH, 16'hffff);
    read_chk(OFF_LATCH, 16'h007f);
    write_reg(OFF_BOOT_BASE, 16'habcd);
    read_chk(OFF_BOOT_BASE, 16'habcd);
    @(posedge clk);
    #1 chk(reg_rdata, 16'h0000);
    write_reg(8'h42, 16'hffff);
    read_chk(8'h42, 16'h0000);
    write_reg(OFF_SEL_LOW, 16'h0001);
    @(posedge clk);
    #1 chk({15'h0000, boot_port_16bit}, 16'h0001);
    $display("test registers done");
  endtask
  // every code on one pin, under all source combinations
  task automatic test_pin(input int idx);
    logic [2:0]  s;
    logic [1:0]  code;
    logic [15:0] fld;
    logic        e_out;
    logic [15:0] own;
    own = (idx >= 3 && idx < 10) ? 16'h0001 << (idx - 3) : 16'h0000;
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      fld = (idx < 6) ? ({14'h0000, code} << (2 * idx + 2)) : ({14'h0000, code} << (2 * (idx - 6)));
      write_reg((idx < 6) ? OFF_SEL_LOW : OFF_SEL_HIGH, fld);
      for (int k = 0; k < 8; k++) begin
        s = k[2:0];
        // only this pin's sources and the e clock carry the tested level, so a crossed route from any other bit shows
        write_reg(OFF_LATCH, 16'h007f & ({16{!s[0]}} ^ own));
        alt_fn_in <= {11{!s[1]}} ^ (11'h001 << idx);
        cs_req_in <= {11{!s[2]}} ^ (11'h001 << idx);
        e_phase_clock <= s[0];
        repeat (2) @(posedge clk);
        #1;
        case (code)
          2'h0: e_out = (idx < 3) ? 1'b1 : s[0];
          2'h1: e_out = s[1];
          default: e_out = ~s[2];
        endcase
        chk({15'h0000, pin_level[idx]}, {15'h0000, e_out});
        chk({15'h0000, cs_pin_oe_n[idx]}, {15'h0000, code == 2'h0 && idx < 3});
        chk({15'h0000, cs_port_16bit[idx]}, {15'h0000, code == 2'h3});
      end
    end
    $display("test pin %0d done", idx);
  endtask
  // boot select window for every block size
  task automatic test_boot;
    int          shift [8] = '{0, 2, 3, 5, 6, 7, 8, 9};
    logic [23:0] sz;
    for (int k = 0; k < 8; k++) begin
      sz = 24'h000800 << shift[k];
      write_reg(OFF_BOOT_BASE, 16'h1000 | k[15:0]);
      for (int t = 0; t < 4; t++) begin
        @(posedge clk);
        bus_addr <= (t == 1) ? 24'h100000 + sz : ((t == 2) ? 24'h0ff800 : 24'h100000 + sz - 1);
        bus_addr_valid <= (t != 3);
        repeat (2) @(posedge clk);
        #1 chk({15'h0000, boot_memory_select_n}, {15'h0000, t != 0});
      end
    end
    @(posedge clk);
    bus_addr_valid <= 1'b0;
    $display("test boot select done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    data_pin = 8'hd6;
    alt_fn_in = 11'h000;
    cs_req_in = 11'h000;
    e_phase_clock = 1'b0;
    bus_addr = 24'h000000;
    bus_addr_valid = 1'b0;
    failures = 0;
    n_compared = 0;
    test_reset(8'hd6, 16'h3ffe, 16'h03d5);
    test_regs;
    for (int p = 0; p < CSPM_NUM_PINS; p++) begin
      test_pin(p);
    end
    test_boot;
    test_reset(8'h00, 16'h1556, 16'h0155);
    complete_run;
  end
  // a hang is cut short here
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule
